// ==== rtl/idle_pkg.sv ====
// constants, types and rule overview for the idle state resolver
// Overview of operation
// (R1) core idle state is the lowest state requested among its threads
// (R2) interrupt, monitor hit or timed deadline returns a thread to C0
// (R3) any thread in C0 makes the core report C0
// (R4) legacy level reads become wait requests and are not issued as I/O
// (R5) only reads inside the capture range redirect; others pass as I/O
// (R6) redirected requests carry sub-state zero
// (R7) redirected requests wake on interrupt even when interrupts are masked
// (R8) C1 needs all threads halted or waiting; snoops still serviced
// (R9) entering C3 flushes first and second level caches; clocks stop
// (R10) snoops or cacheable accesses never wake a core in C3
// (R11) C6 saves state to on-chip memory before removing voltage; restores on exit
// (R12) C7 and C8 requests behave as C6 for the core
// (R13) auto-demotion sends deep requests to C3 or C1 until residency suffices
// (R14) auto-demotion is off after reset; firmware enables it
// (R15) package request is lowest core state; C0 C2 C3 C6 C7 C8 supported
// (R16) package enters a state only with platform grant
// (R17) package may move between states without passing C0
// (R18) core break wakes target; unmasked gives C0, masked re-enters previous
// (R19) memory or snoop break returns to previous state unless platform holds higher
// (R20) package stays C0 while a core is in C0 or C1 or no grant
// (R21) package C2 when cores deep, graphics idle but constraints block deeper
// (R22) memory access while cores deep gives C2 until requests complete
// (R23) thread and core pass through C0 between low-power states; auto-demotion moves the core directly between C3 and the deep states, and from either to C1
// (R24) package C3 when cores C3 or deeper and grant allows C3 only
// (R25) platform grant is a level naming the deepest allowed package state
// (R26) all break sources handled in one clock; core breaks take priority; here mem_access and snoop_req pass two flops first
package idle_pkg;
	localparam int n_cores = 2;
	localparam int n_threads = 2;
	localparam int n_thr_all = n_cores * n_threads;
	// idle state codes, numerically ordered by depth
	localparam logic [3:0] st_c0 = 4'h0;
	localparam logic [3:0] st_c1 = 4'h1;
	localparam logic [3:0] st_c2 = 4'h2;
	localparam logic [3:0] st_c3 = 4'h3;
	localparam logic [3:0] st_c6 = 4'h6;
	localparam logic [3:0] st_c7 = 4'h7;
	localparam logic [3:0] st_c8 = 4'h8;
	// legacy level read: level n maps to state table below
	localparam logic [15:0] io_base_reset = 16'h0000;
	localparam logic [15:0] io_limit_reset = 16'h0000;
	// core idle config control bits
	localparam int cfg_demote_c3_bit = 0;
	localparam int cfg_demote_c1_bit = 1;
	localparam logic [1:0] cfg_reset = 2'h0;
	// residency needed before deep entry, and interrupt counts that demote
	localparam int res_ns = 1000;
	localparam int clk_ns = 8;
	localparam int res_cycles = (res_ns + clk_ns - 1) / clk_ns;
	localparam logic [7:0] res_need = 8'(res_cycles);
	localparam logic [3:0] irq_demote_c3 = 4'h2;
	localparam logic [3:0] irq_demote_c1 = 4'h4;
	// save and restore step counts for the state memory
	localparam logic [3:0] save_words = 4'h4;
	// apb map
	localparam logic [11:0] addr_cfg = 12'h000;
	localparam logic [11:0] addr_io_range = 12'h004;
	localparam logic [11:0] addr_core_state = 12'h008;
	localparam logic [11:0] addr_pkg_state = 12'h00c;
	localparam logic [11:0] addr_io_fwd = 12'h010;

	typedef enum logic [2:0] {cs_run, cs_save, cs_idle, cs_restore} core_phase_e;

	function automatic logic [3:0] lvl_to_state(input logic [2:0] lvl);
		unique case (lvl)
			3'h2: lvl_to_state = st_c3;
			3'h3: lvl_to_state = st_c6;
			3'h4: lvl_to_state = st_c7;
			3'h5: lvl_to_state = st_c7;
			3'h6: lvl_to_state = st_c8;
			3'h7: lvl_to_state = st_c8;
			default: lvl_to_state = st_c1;
		endcase
	endfunction

	function automatic logic [3:0] min_state(input logic [3:0] a, input logic [3:0] b);
		min_state = (a < b) ? a : b;
	endfunction

	function automatic logic is_deep(input logic [3:0] s);
		is_deep = (s >= st_c6);
	endfunction
endpackage

// ==== rtl/state_save_mem.sv ====
// small memory holding saved architectural state words
`timescale 1ns/1ps
module state_save_mem (
	input wire logic pclk,
	input wire logic we,
	input wire logic [3:0] waddr,
	input wire logic [31:0] wdata,
	input wire logic [3:0] raddr,
	output logic [31:0] rdata
);
	logic [31:0] mem [0:15];

	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // state_save_mem

// ==== rtl/idle_state_resolver.sv ====
// thread, core and package idle state resolution with apb registers
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module idle_state_resolver
	import idle_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [n_thr_all-1:0] wait_req,
	input wire logic [n_thr_all*4-1:0] wait_state,
	input wire logic [n_thr_all-1:0] halt_instruction,
	input wire logic [n_thr_all-1:0] io_read_req,
	input wire logic [n_thr_all*16-1:0] io_read_addr,
	input wire logic [n_thr_all-1:0] thread_irq,
	input wire logic [n_thr_all-1:0] interrupt_enable_flag,
	input wire logic [n_thr_all-1:0] monitor_hit,
	input wire logic [n_thr_all-1:0] timed_deadline,
	input wire logic snoop_req,
	input wire logic mem_access,
	input wire logic mem_outstanding,
	input wire logic [3:0] platform_grant,
	input wire logic platform_hold_high,
	input wire logic graphics_idle_state,
	input wire logic deep_blocked,
	output logic [n_thr_all-1:0] io_forward,
	output logic [n_thr_all-1:0] thread_awake,
	output logic [n_thr_all-1:0] thread_substate_zero,
	output logic [n_cores*4-1:0] core_state,
	output logic [n_cores-1:0] cache_flush,
	output logic [n_cores-1:0] core_clk_stop,
	output logic [n_cores-1:0] core_power_off,
	output logic [n_cores-1:0] snoop_service,
	output logic [3:0] pkg_state
);
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [1:0] cfg;
		logic [15:0] io_base;
		logic [15:0] io_limit;
		logic [n_thr_all-1:0] io_fwd;
		logic [n_thr_all*4-1:0] thr_state;
		logic [n_thr_all-1:0] brk_irq;
		logic [n_thr_all-1:0] sub0;
		logic [n_cores*4-1:0] core_st;
		logic [n_cores*3-1:0] phase;
		logic [n_cores*8-1:0] resid;
		logic [n_cores*4-1:0] irq_cnt;
		logic [n_cores*4-1:0] step;
		logic [n_cores-1:0] flush;
		logic [n_cores-1:0] clk_stop;
		logic [n_cores-1:0] pwr_off;
		logic [n_cores-1:0] snoop_svc;
		logic [3:0] pkg;
		logic [3:0] pkg_prev;
		logic [3:0] grant0;
		logic [3:0] grant;
		logic hold0;
		logic hold;
		logic mem0;
		logic mem1;
		logic snp0;
		logic snp1;
	} state_s;

	state_s r, next_r;
	logic mem_we;
	logic [3:0] mem_waddr;
	logic [31:0] mem_wdata;
	logic [31:0] mem_rdata;

	state_save_mem u_mem (
		.pclk(pclk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_waddr),
		.rdata(mem_rdata)
	);

	always_comb begin
		logic [3:0] req;
		logic [3:0] cst;
		logic [3:0] pkg_req;
		logic [3:0] pkg_tgt;
		logic [15:0] a;
		logic any_c0;
		logic all_halt;
		logic core_brk;
		logic core_brk_unmasked;
		logic [2:0] ph;
		logic [7:0] res;
		logic [3:0] ic;
		logic [3:0] stp;
		int t;
		req = st_c0;
		cst = st_c0;
		pkg_req = st_c8;
		pkg_tgt = st_c0;
		a = 16'h0000;
		any_c0 = 1'b0;
		all_halt = 1'b1;
		core_brk = 1'b0;
		core_brk_unmasked = 1'b0;
		ph = 3'h0;
		res = 8'h00;
		ic = 4'h0;
		stp = 4'h0;
		t = 0;
		next_r = r;
		mem_we = 1'b0;
		mem_waddr = 4'h0;
		mem_wdata = 32'h00000000;
		// apb slave: answers in the access cycle with no wait state
		next_r.pready = psel && !penable;
		next_r.pslverr = 1'b0;
		if (psel && !penable) begin
			next_r.prdata = 32'h00000000;
			unique case (paddr)
				addr_cfg: next_r.prdata = {30'h0, r.cfg};
				addr_io_range: next_r.prdata = {r.io_limit, r.io_base};
				addr_core_state: next_r.prdata = {{(32 - n_cores * 4){1'b0}}, r.core_st};
				addr_pkg_state: next_r.prdata = {28'h0, r.pkg};
				addr_io_fwd: next_r.prdata = {{(32 - n_thr_all){1'b0}}, r.io_fwd};
				default: next_r.pslverr = 1'b1;
			endcase
		end
		// writes land at the edge where the access phase meets pready
		if (psel && penable && r.pready && pwrite) begin
			unique case (paddr)
				addr_cfg: next_r.cfg = pwdata[1:0]; // [R14]
				addr_io_range: begin
					next_r.io_base = pwdata[15:0];
					next_r.io_limit = pwdata[31:16];
				end
				default: ;
			endcase
		end
		// platform inputs pass two flops
		next_r.grant0 = platform_grant; // [R25]
		next_r.grant = r.grant0;
		next_r.hold0 = platform_hold_high;
		next_r.hold = r.hold0;
		next_r.mem0 = mem_access;
		next_r.mem1 = r.mem0;
		next_r.snp0 = snoop_req;
		next_r.snp1 = r.snp0;
		// thread requests and wakes
		for (t = 0; t < n_thr_all; t++) begin
			next_r.io_fwd[t] = 1'b0;
			a = io_read_addr[t*16 +: 16];
			if (thread_irq[t] && (interrupt_enable_flag[t] || r.brk_irq[t])) begin
				next_r.thr_state[t*4 +: 4] = st_c0; // [R2]
			end else if (r.thr_state[t*4 +: 4] != st_c0 &&
					((monitor_hit[t] && !r.sub0[t]) || timed_deadline[t])) begin
				// a redirected level read arms no monitor, so hits wake only wait and halt entries
				next_r.thr_state[t*4 +: 4] = st_c0; // [R2]
			end else if (r.thr_state[t*4 +: 4] == st_c0) begin
				// new requests only from C0 [R23]
				if (io_read_req[t]) begin
					if (a >= r.io_base && a <= r.io_limit && a[2:0] >= 3'h1) begin
						next_r.thr_state[t*4 +: 4] = lvl_to_state(a[2:0]); // [R4] [R5]
						next_r.sub0[t] = 1'b1; // [R6]
						next_r.brk_irq[t] = 1'b1; // [R7]
					end else begin
						next_r.io_fwd[t] = 1'b1; // [R5]
					end
				end else if (wait_req[t]) begin
					next_r.thr_state[t*4 +: 4] = wait_state[t*4 +: 4];
					next_r.sub0[t] = 1'b0;
					next_r.brk_irq[t] = 1'b0;
				end else if (halt_instruction[t]) begin
					next_r.thr_state[t*4 +: 4] = st_c1;
					next_r.sub0[t] = 1'b0;
					next_r.brk_irq[t] = 1'b0;
				end
			end
		end
		// core resolution
		for (int c = 0; c < n_cores; c++) begin
			req = st_c8;
			any_c0 = 1'b0;
			for (int k = 0; k < n_threads; k++) begin
				req = min_state(req, r.thr_state[(c*n_threads+k)*4 +: 4]); // [R1]
				if (r.thr_state[(c*n_threads+k)*4 +: 4] == st_c0) begin
					any_c0 = 1'b1;
				end
			end
			// C1 only when no thread remains in C0 [R8]
			cst = any_c0 ? st_c0 : req; // [R3]
			res = r.resid[c*8 +: 8];
			ic = r.irq_cnt[c*4 +: 4];
			core_brk = |thread_irq[c*n_threads +: n_threads];
			if (core_brk && ic != 4'hf) begin
				ic = ic + 4'h1;
			end
			if (res < res_need && cst >= st_c3) begin
				if (r.cfg[cfg_demote_c1_bit] && ic >= irq_demote_c1) begin
					cst = st_c1; // [R13]
				end else if (r.cfg[cfg_demote_c3_bit] && ic >= irq_demote_c3 && is_deep(cst)) begin
					cst = st_c3; // [R13]
				end
			end
			if (cst >= st_c3 && res != 8'hff) begin
				res = res + 8'h01;
			end
			if (cst == st_c0 && res == 8'h00) begin
				ic = 4'h0;
			end
			if (core_brk) begin
				res = 8'h00;
			end
			next_r.resid[c*8 +: 8] = res;
			next_r.irq_cnt[c*4 +: 4] = ic;
			// deep entry saves state first, exit restores [R11] [R12]
			ph = r.phase[c*3 +: 3];
			stp = r.step[c*4 +: 4];
			unique case (core_phase_e'(ph))
				cs_run: begin
					if (is_deep(cst)) begin
						ph = 3'(cs_save);
						stp = 4'h0;
					end
				end
				cs_save: begin
					mem_we = 1'b1;
					mem_waddr = 4'(c * 8) + stp;
					mem_wdata = {28'h0, stp};
					stp = stp + 4'h1;
					if (stp == save_words) begin
						ph = 3'(cs_idle);
					end
				end
				cs_idle: begin
					if (!is_deep(cst)) begin
						ph = 3'(cs_restore);
						stp = 4'h0;
					end
				end
				cs_restore: begin
					mem_waddr = 4'(c * 8) + stp;
					stp = stp + 4'h1;
					if (stp == save_words) begin
						ph = 3'(cs_run);
					end
				end
				default: ph = 3'(cs_run);
			endcase
			next_r.phase[c*3 +: 3] = ph;
			next_r.step[c*4 +: 4] = stp;
			next_r.core_st[c*4 +: 4] = cst;
			next_r.flush[c] = (cst >= st_c3); // [R9]
			next_r.clk_stop[c] = (cst >= st_c3); // [R9] [R10]
			next_r.pwr_off[c] = (core_phase_e'(ph) == cs_idle); // [R11] [R12]
			next_r.snoop_svc[c] = (cst <= st_c1) && r.snp1; // [R8] [R10]
			pkg_req = min_state(pkg_req, r.core_st[c*4 +: 4]); // [R15]
		end
		// package resolution
		core_brk = |thread_irq;
		core_brk_unmasked = |(thread_irq & (interrupt_enable_flag | r.brk_irq));
		pkg_tgt = min_state(pkg_req, r.grant); // [R16]
		if (pkg_tgt == st_c6 && pkg_req >= st_c7) begin
			pkg_tgt = st_c6;
		end
		if (pkg_req >= st_c3 && pkg_tgt <= st_c2) begin
			pkg_tgt = (graphics_idle_state && r.grant >= st_c2) ? st_c2 : st_c0; // [R21]
		end else if (pkg_req >= st_c3 && deep_blocked && graphics_idle_state) begin
			pkg_tgt = st_c2; // [R21]
		end
		if (core_brk) begin
			// core breaks win over memory or snoop breaks [R26]
			pkg_tgt = core_brk_unmasked ? st_c0 : r.pkg; // [R18]
		end else if ((r.mem1 || r.snp1 || mem_outstanding) && pkg_req >= st_c3 &&
				r.grant >= st_c2) begin
			// stays in C2, or C0 while the platform holds, until the last outstanding access is done [R22] [R19]
			pkg_tgt = r.hold ? st_c0 : st_c2;
		end else if (r.hold && r.pkg < pkg_tgt) begin
			// platform keeps the package at the higher power level it woke to [R19]
			pkg_tgt = r.pkg;
		end
		// checked last so that no break path can leave C0 without a grant
		if (pkg_req <= st_c1 || r.grant == st_c0) begin
			pkg_tgt = st_c0; // [R20]
		end
		// direct moves between package states allowed [R17] [R24]
		next_r.pkg = pkg_tgt;
		if (pkg_tgt != r.pkg) begin
			next_r.pkg_prev = r.pkg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.cfg <= cfg_reset;
			r.io_base <= io_base_reset;
			r.io_limit <= io_limit_reset;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign io_forward = r.io_fwd;
	assign thread_awake = r.brk_irq;
	assign thread_substate_zero = r.sub0;
	assign core_state = r.core_st;
	assign cache_flush = r.flush;
	assign core_clk_stop = r.clk_stop;
	assign core_power_off = r.pwr_off;
	assign snoop_service = r.snoop_svc;
	assign pkg_state = r.pkg;

	demote_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		$rose(presetn) |-> r.cfg == 2'h0)
		else $error("demotion enabled after reset");
	pkg_grant_a: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		(r.grant == st_c0) |=> (r.pkg == st_c0) || $past(|thread_irq))
		else $error("package left C0 without grant");
	c3_flush_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		(r.core_st[3:0] >= st_c3) |-> r.flush[0])
		else $error("core C3 without flush");
	core_c0_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		(r.thr_state[3:0] == st_c0) |=> (r.core_st[3:0] == st_c0))
		else $error("core not C0 with active thread");
	irq_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		(thread_irq[0] && interrupt_enable_flag[0]) |=> r.thr_state[3:0] == st_c0)
		else $error("interrupt did not wake thread");
	redirect_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		$rose(r.sub0[2]) |-> r.brk_irq[2])
		else $error("redirected request lacks break on interrupt");
	pkg_c1_a: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
		(r.core_st[3:0] <= st_c1 && !(|thread_irq)) |=> r.pkg == st_c0)
		else $error("package left C0 while core active");
	power_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		$rose(r.pwr_off[0]) |-> $past(r.phase[2:0], 2) == 3'(cs_save))
		else $error("power removed before save");
	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.pready |=> !r.pready)
		else $error("pready stood longer than the access phase");
	via_c0_a: assert property (@(posedge pclk) disable iff (!presetn) // [R23]
		(r.thr_state[3:0] != st_c0) |=> (r.thr_state[3:0] == st_c0) ||
		$stable(r.thr_state[3:0]))
		else $error("thread moved between idle states without C0");
	mem_c2_a: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
		(mem_outstanding && !(|thread_irq) && !r.hold && r.grant >= st_c2 &&
		r.core_st[3:0] >= st_c3 && r.core_st[7:4] >= st_c3) |=> r.pkg == st_c2)
		else $error("memory access with deep cores did not give package C2");
endmodule // idle_state_resolver

// ==== verification/platform_model.sv ====
// platform controller model that grants package low-power permission
`timescale 1ns/1ps
module platform_model
	import idle_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] grant_level,
	input wire logic hold_req,
	output logic [3:0] platform_grant,
	output logic platform_hold_high
);
	// grant is a steady level that changes only just after a clock edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			platform_grant <= st_c0;
			platform_hold_high <= 1'b0;
		end else begin
			platform_grant <= grant_level;
			platform_hold_high <= hold_req;
		end
	end
endmodule // platform_model

// ==== verification/tb_top.sv ====
// self-checking bench for the idle state resolver
`timescale 1ns/1ps
module tb_top;
	import idle_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] wait_req = 4'h0;
	logic [15:0] wait_state = 16'h0;
	logic [3:0] halt_instruction = 4'h0;
	logic [3:0] io_read_req = 4'h0;
	logic [63:0] io_read_addr = 64'h0;
	logic [3:0] thread_irq = 4'h0;
	logic [3:0] interrupt_enable_flag = 4'hf;
	logic [3:0] monitor_hit = 4'h0;
	logic [3:0] timed_deadline = 4'h0;
	logic snoop_req = 1'b0;
	logic mem_access = 1'b0;
	logic mem_outstanding = 1'b0;
	logic [3:0] platform_grant;
	logic platform_hold_high;
	logic graphics_idle_state = 1'b0;
	logic deep_blocked = 1'b0;
	logic [3:0] grant_level = 4'h0;
	logic hold_req = 1'b0;
	logic [3:0] io_forward, thread_awake, thread_substate_zero, pkg_state;
	logic [7:0] core_state;
	logic [1:0] cache_flush, core_clk_stop, core_power_off, snoop_service;
	int err_total = 0;
	int num_checks = 0;
	int seed = 22;
	logic [31:0] rd;
	logic er;
	logic [3:0] a, b;

	always #4 pclk = ~pclk;

	idle_state_resolver i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wait_req(wait_req), .wait_state(wait_state),
		.halt_instruction(halt_instruction), .io_read_req(io_read_req),
		.io_read_addr(io_read_addr), .thread_irq(thread_irq),
		.interrupt_enable_flag(interrupt_enable_flag), .monitor_hit(monitor_hit),
		.timed_deadline(timed_deadline), .snoop_req(snoop_req), .mem_access(mem_access),
		.mem_outstanding(mem_outstanding), .platform_grant(platform_grant),
		.platform_hold_high(platform_hold_high), .graphics_idle_state(graphics_idle_state),
		.deep_blocked(deep_blocked), .io_forward(io_forward), .thread_awake(thread_awake),
		.thread_substate_zero(thread_substate_zero), .core_state(core_state),
		.cache_flush(cache_flush), .core_clk_stop(core_clk_stop),
		.core_power_off(core_power_off), .snoop_service(snoop_service), .pkg_state(pkg_state));

	platform_model i_plat (.pclk(pclk), .presetn(presetn), .grant_level(grant_level),
		.hold_req(hold_req), .platform_grant(platform_grant),
		.platform_hold_high(platform_hold_high));

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [3:0] probe(input int sel, input int i);
		case (sel)
			0: probe = core_state[i*4 +: 4];
			1: probe = pkg_state;
			2: probe = {3'h0, core_power_off[i]};
			3: probe = {3'h0, core_clk_stop[i]};
			4: probe = {3'h0, io_forward[i]};
			default: probe = {3'h0, snoop_service[i]};
		endcase
	endfunction

	// poll an output under a bound, then compare
	task automatic await(input string nm, input int sel, input int i, input logic [3:0] e);
		int n = 0;
		while (probe(sel, i) !== e && n < 60) begin
			@(posedge pclk);
			n++;
		end
		check(nm, 32'(probe(sel, i)), 32'(e));
	endtask

	function automatic logic [3:0] pick(input int unsigned r);
		logic [3:0] tbl [5] = '{st_c1, st_c3, st_c6, st_c7, st_c8};
		pick = tbl[r % 5];
	endfunction

	function automatic logic [3:0] lower(input logic [3:0] x, input logic [3:0] y);
		lower = (x < y) ? x : y;
	endfunction

	initial begin
		#(8 * 30000);
		err_total++;
		give_verdict();
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("core_state rst", 32'(core_state), 32'h0);
		apb(1'b0, addr_cfg, 32'h0);
		check("cfg rst", rd, 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		check("unmapped err", 32'(er), 32'h1);
		apb(1'b1, addr_cfg, 32'h3);
		apb(1'b0, addr_cfg, 32'h0);
		check("cfg rw", rd, 32'h3);
		apb(1'b1, addr_cfg, 32'h0);
		for (int k = 0; k < 6; k++) begin
			a = pick($unsigned($random(seed)));
			b = pick($unsigned($random(seed)));
			if (k == 0) begin
				a = st_c1;
				b = st_c8;
			end
			wait_state[7:0] <= {b, a};
			wait_req <= 4'b0011;
			@(posedge pclk);
			wait_req <= 4'h0;
			await("core min", 0, 0, lower(a, b));
			thread_irq <= 4'b0001;
			@(posedge pclk);
			thread_irq <= 4'h0;
			await("core active", 0, 0, st_c0);
			wait_state[3:0] <= st_c8;
			wait_req <= 4'b0001;
			@(posedge pclk);
			wait_req <= 4'h0;
			await("other asleep", 0, 0, b);
			if (k[0]) monitor_hit <= 4'b0011;
			else timed_deadline <= 4'b0011;
			@(posedge pclk);
			monitor_hit <= 4'h0;
			timed_deadline <= 4'h0;
			await("core wake", 0, 0, st_c0);
		end
		apb(1'b1, addr_io_range, {16'h0417, 16'h0410});
		apb(1'b0, addr_io_range, 32'h0);
		check("io range rw", rd, {16'h0417, 16'h0410});
		io_read_addr[63:32] <= {16'h0412, 16'h0412};
		io_read_req <= 4'b1100;
		@(posedge pclk);
		io_read_req <= 4'h0;
		await("redirect c3", 0, 1, st_c3);
		check("no forward", 32'(io_forward), 32'h0);
		check("substate zero", 32'(thread_substate_zero[3:2]), 32'h3);
		check("break on irq", 32'(thread_awake[3:2]), 32'h3);
		await("clk stop", 3, 1, 4'h1);
		io_read_addr[15:0] <= 16'h0500;
		io_read_req <= 4'b0001;
		@(posedge pclk);
		io_read_req <= 4'h0;
		await("forward", 4, 0, 4'h1);
		grant_level <= st_c8;
		await("pkg core c0", 1, 0, st_c0);
		wait_state[7:0] <= {st_c6, st_c6};
		wait_req <= 4'b0011;
		@(posedge pclk);
		wait_req <= 4'h0;
		await("power off", 2, 0, 4'h1);
		await("pkg c3", 1, 0, st_c3);
		grant_level <= st_c0;
		await("no grant", 1, 0, st_c0);
		grant_level <= st_c8;
		await("regrant", 1, 0, st_c3);
		graphics_idle_state <= 1'b1;
		mem_outstanding <= 1'b1;
		await("mem break c2", 1, 0, st_c2);
		mem_outstanding <= 1'b0;
		await("mem done", 1, 0, st_c3);
		deep_blocked <= 1'b1;
		await("blocked c2", 1, 0, st_c2);
		deep_blocked <= 1'b0;
		hold_req <= 1'b1;
		repeat (4) @(posedge pclk);
		snoop_req <= 1'b1;
		await("held c0", 1, 0, st_c0);
		snoop_req <= 1'b0;
		repeat (4) @(posedge pclk);
		check("stays c0", 32'(pkg_state), 32'(st_c0));
		hold_req <= 1'b0;
		await("released", 1, 0, st_c3);
		interrupt_enable_flag <= 4'h0;
		thread_irq <= 4'b0100;
		@(posedge pclk);
		thread_irq <= 4'h0;
		await("masked wake", 0, 1, st_c0);
		await("pkg break", 1, 0, st_c0);
		timed_deadline <= 4'b0011;
		@(posedge pclk);
		timed_deadline <= 4'h0;
		await("deadline wake", 0, 0, st_c0);
		apb(1'b1, addr_cfg, 32'h1);
		wait_state[7:0] <= {st_c6, st_c6};
		wait_req <= 4'b0011;
		@(posedge pclk);
		wait_req <= 4'h0;
		await("deep again", 0, 0, st_c6);
		repeat (irq_demote_c3) begin
			thread_irq <= 4'b0001;
			@(posedge pclk);
			thread_irq <= 4'h0;
			@(posedge pclk);
		end
		await("demote c3", 0, 0, st_c3);
		snoop_req <= 1'b1;
		await("snoop served", 5, 1, 4'h1);
		check("no snoop wake", 32'(core_state[3:0]), 32'(st_c3));
		check("no snoop svc", 32'(snoop_service[0]), 32'h0);
		check("flush c3", 32'(cache_flush[0]), 32'h1);
		snoop_req <= 1'b0;
		give_verdict();
	end
endmodule // tb_top
